// ---- rtl/sac_ctrl.sv ----
// Converter control: registers, start sources, tracking, SAR sequencing
// Function
// - Converter, track-and-hold and gain stage work only while enabled.
// - Selector offers eight external inputs plus internal temperature sensor.
// - Adjacent pairs differential or single-ended; all single-ended at reset.
// - Three-bit gain code selects 0.5 to 16; unity after reset.
// - Gain codes: 000=1, 001=2, 010=4, 011=8, 10x=16, 11x=0.5.
// - Conversion clock from system clock; rate capped at 100 ksps.
// - Five-bit divider field; conversion clock is system clock/(field+1).
// - Four start sources chosen by two-bit start-source field.
// - Source codes: 00 busy write, 01 timer3, 10 pin rise, 11 timer2.
// - Busy reads one during conversion, zero once it completes.
// - Busy falling at completion sets done flag at control bit 5; disable drops busy without it.
// - Twelve-bit result left or right justified across high/low pair.
// - Low-power tracking off: input tracked whenever not converting.
// - Low-power tracking on: three conversion clocks tracking after start.
// - Pin start in low-power mode: track while low, convert on rise.
// - No tracking while the chip is in standby or sleep.
// - Temperature sensor goes through the gain stage at programmed gain.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              timer3_ovf,
  input  wire logic              timer2_ovf,
  input  wire logic              convert_start_pin,
  input  wire logic              sar_cmp_pin,
  input  wire logic              chip_standby,
  output logic                   converter_power,
  output logic                   track_en,
  output logic [RES_W-1:0]       sar_dac,
  output logic [3:0]             channel_code,
  output logic [3:0]             pair_config,
  output logic                   temp_sensor_sel,
  output logic [GSEL_W-1:0]      gain_sel,
  output logic                   conversion_done_flag,
  output logic                   conversion_busy
);

  // Pin synchronisers
  logic [1:0] pin_sync_q;
  logic [1:0] cmp_sync_q;
  logic       pin_prev_q;

  // Bus and registers
  logic        ack_q;
  logic [31:0] dat_q;
  logic [3:0]  pair_cfg_q;
  logic [3:0]  chan_sel_q;
  logic [7:0]  conv_cfg_q;
  logic        enable_q;
  logic        lp_track_q;
  logic        done_q;
  logic [1:0]  src_q;
  logic        ljust_q;
  logic [RES_W-1:0] result_q;

  // Conversion engine
  sac_state_t       state_q;
  sac_state_t       state_d;
  logic [DIV_W-1:0] div_cnt_q;
  logic [1:0]       trk_cnt_q;
  logic [PER_W-1:0] per_q;
  logic             track_q;
  logic             power_q;
  logic [GSEL_W-1:0] gsel_q;

  // Decode wires
  logic       req;
  logic       wr_fire;
  logic [9:0] reg_idx;
  logic       wr_ctrl;
  logic [7:0] wbyte;
  logic       sw_start;
  logic       pin_rise;
  logic       src_event;
  logic       start_ok;
  logic       use_lp_track;
  logic       sar_tick;
  logic       sar_start;
  logic       sar_done;
  logic       busy;
  logic       busy_fall;
  logic       period_met;
  logic       track_d;
  logic [7:0] ctrl_rd;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic [7:0] rd_byte;
  logic [RES_W-1:0] sar_result;
  logic [DIV_W-1:0] div_field;

  function automatic logic [GSEL_W-1:0] gain_decode(
      input logic [GAIN_W-1:0] code);
    gain_decode = '0;
    case (code)
      3'h0:    gain_decode[GSEL_X1] = 1'b1;
      3'h1:    gain_decode[GSEL_X2] = 1'b1;
      3'h2:    gain_decode[GSEL_X4] = 1'b1;
      3'h3:    gain_decode[GSEL_X8] = 1'b1;
      3'h4,
      3'h5:    gain_decode[GSEL_X16] = 1'b1;
      default: gain_decode[GSEL_HALF] = 1'b1;
    endcase
  endfunction

  // Bus decode; write lands on the edge where the master sees ack
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & ack_q & wb_we_i & wb_sel_i[0];
  assign reg_idx = wb_adr_i[11:2];
  assign wbyte   = wb_dat_i[7:0];
  assign wr_ctrl = wr_fire & (reg_idx == IDX_CONV_CTRL);

  // Edge and start-source selection
  assign pin_rise  = pin_sync_q[1] & ~pin_prev_q;
  assign sw_start  = wr_ctrl & wbyte[CTL_BUSY] & (src_q == SRC_BUSY_WR);
  assign src_event = (src_q == SRC_BUSY_WR) ? sw_start   :
                     (src_q == SRC_TIMER3)  ? timer3_ovf :
                     (src_q == SRC_PIN)     ? pin_rise   :
                                              timer2_ovf;
  // Only an idle, enabled converter accepts a start
  assign start_ok  = enable_q & (state_q == ST_IDLE) & src_event;
  // Pin mode already tracked while the pin sat low
  assign use_lp_track = lp_track_q & (src_q != SRC_PIN);

  // Divider restarts at each start so tracking spans whole periods
  assign div_field = conv_cfg_q[CFG_DIV_LSB +: DIV_W];
  assign sar_tick  = (div_cnt_q == div_field);
  assign sar_start = (start_ok & ~use_lp_track) |
                     ((state_q == ST_TRACK) & sar_tick &
                      (trk_cnt_q == LP_TRACK_TICKS - 2'h1));
  assign period_met = (per_q >= MIN_CONV_LAST);

  assign busy      = (state_q != ST_IDLE);
  assign busy_fall = (state_q == ST_HOLD) & period_met;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok)
          state_d = use_lp_track ? ST_TRACK : ST_CONV;
      end
      ST_TRACK: begin
        if (sar_start)
          state_d = ST_CONV;
      end
      ST_CONV: begin
        if (sar_done)
          state_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (period_met)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (!enable_q)
      state_d = ST_IDLE;
  end

  // Tracking window per mode; standby always stops it
  assign track_d = enable_q & ~chip_standby &
                   ((~lp_track_q & (state_q == ST_IDLE)) |
                    (state_q == ST_TRACK) |
                    (lp_track_q & (src_q == SRC_PIN) &
                     (state_q == ST_IDLE) & ~pin_sync_q[1]));

  // Justification applied on read so the bit may change any time
  assign res_high = ljust_q ? result_q[11:4]
                            : {4'h0, result_q[11:8]};
  assign res_low  = ljust_q ? {result_q[3:0], 4'h0}
                            : result_q[7:0];
  assign ctrl_rd  = {enable_q, lp_track_q, done_q, busy,
                     src_q, 1'b0, ljust_q};
  assign rd_byte  = (reg_idx == IDX_PAIR_CFG)  ? {4'h0, pair_cfg_q} :
                    (reg_idx == IDX_CHAN_SEL)  ? {4'h0, chan_sel_q} :
                    (reg_idx == IDX_CONV_CFG)  ? conv_cfg_q :
                    (reg_idx == IDX_CONV_CTRL) ? ctrl_rd :
                    (reg_idx == IDX_RES_HIGH)  ? res_high :
                    (reg_idx == IDX_RES_LOW)   ? res_low : 8'h00;

  sac_sar_seq u_sar (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (sar_tick),
    .start    (sar_start),
    .abort    (~enable_q),
    .cmp      (cmp_sync_q[1]),
    .dac_q    (sar_dac),
    .result_q (sar_result),
    .done_q   (sar_done)
  );

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_sync_q <= 2'h3;
      cmp_sync_q <= 2'h0;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[0], convert_start_pin};
      cmp_sync_q <= {cmp_sync_q[0], sar_cmp_pin};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // Bus slave: ack one cycle after request, dropped the next
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
        dat_q <= {24'h0, rd_byte};
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pair_cfg_q <= PAIR_CFG_RST;
      chan_sel_q <= CHAN_SEL_RST;
      conv_cfg_q <= CONV_CFG_RST;
    end else if (wr_fire) begin
      if (reg_idx == IDX_PAIR_CFG)
        pair_cfg_q <= wbyte[3:0];
      if (reg_idx == IDX_CHAN_SEL)
        chan_sel_q <= wbyte[3:0];
      if (reg_idx == IDX_CONV_CFG)
        conv_cfg_q <= wbyte;
    end
  end

  // Control register; done flag set wins over software clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable_q   <= 1'b0;
      lp_track_q <= 1'b0;
      done_q     <= 1'b0;
      src_q      <= SRC_BUSY_WR;
      ljust_q    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_q   <= wbyte[CTL_ENABLE];
        lp_track_q <= wbyte[CTL_LP_TRACK];
        src_q      <= wbyte[CTL_SRC_HI:CTL_SRC_LO];
        ljust_q    <= wbyte[CTL_LJUST];
        done_q     <= wbyte[CTL_DONE];
      end
      if (busy_fall)
        done_q <= 1'b1;
    end
  end

  // Conversion engine state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      div_cnt_q <= '0;
      trk_cnt_q <= '0;
      per_q     <= '0;
      result_q  <= '0;
    end else begin
      state_q   <= state_d;
      div_cnt_q <= (start_ok | sar_tick) ? '0 : div_cnt_q + 5'h1;
      if (start_ok)
        trk_cnt_q <= '0;
      else if ((state_q == ST_TRACK) && sar_tick)
        trk_cnt_q <= trk_cnt_q + 2'h1;
      per_q <= start_ok ? '0 : (busy & ~period_met) ? per_q + 12'h001
                                                    : per_q;
      if (sar_done)
        result_q <= sar_result;
    end
  end

  // Analog-side controls
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      track_q <= 1'b0;
      power_q <= 1'b0;
      gsel_q  <= '0;
    end else begin
      track_q <= track_d;
      power_q <= enable_q;
      // Gain applies to every channel, temperature sensor included
      gsel_q  <= enable_q ? gain_decode(conv_cfg_q[CFG_GAIN_LSB +: GAIN_W])
                          : '0;
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = dat_q;
  assign converter_power      = power_q;
  assign track_en             = track_q;
  assign channel_code         = chan_sel_q;
  assign pair_config          = pair_cfg_q;
  assign temp_sensor_sel      = chan_sel_q[CHAN_TEMP_BIT];
  assign gain_sel             = gsel_q;
  assign conversion_done_flag = done_q;
  assign conversion_busy      = state_q != ST_IDLE ? 1'b1 : 1'b0;

endmodule

// ---- rtl/sac_pkg.sv ----
// Package: constants for the converter control block
package sac_pkg;

  // Clock and timing
  localparam int SYS_CLK_MHZ  = 200;
  localparam int MIN_CONV_NS  = 10000;
  localparam int MIN_CONV_CYC = (MIN_CONV_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int PER_W        = 12;
  localparam logic [PER_W-1:0] MIN_CONV_LAST = PER_W'(MIN_CONV_CYC - 1);
  localparam logic [1:0] LP_TRACK_TICKS = 2'h3;

  // Result and field widths
  localparam int RES_W  = 12;
  localparam int IDX_W  = 4;
  localparam int DIV_W  = 5;
  localparam int GAIN_W = 3;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PAIR_CFG   = 10'h0BA;
  localparam logic [9:0] IDX_CHAN_SEL   = 10'h0BB;
  localparam logic [9:0] IDX_CONV_CFG   = 10'h0BC;
  localparam logic [9:0] IDX_RES_LOW    = 10'h0BE;
  localparam logic [9:0] IDX_RES_HIGH   = 10'h0BF;
  localparam logic [9:0] IDX_CONV_CTRL  = 10'h0E8;

  // Reset values
  localparam logic [3:0] PAIR_CFG_RST  = 4'h0;
  localparam logic [3:0] CHAN_SEL_RST  = 4'h0;
  localparam logic [7:0] CONV_CFG_RST  = 8'hF8;

  // Control register bit positions
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_LP_TRACK = 6;
  localparam int CTL_DONE     = 5;
  localparam int CTL_BUSY     = 4;
  localparam int CTL_SRC_HI   = 3;
  localparam int CTL_SRC_LO   = 2;
  localparam int CTL_LJUST    = 0;

  // Configuration register fields
  localparam int CFG_DIV_LSB  = 3;
  localparam int CFG_GAIN_LSB = 0;

  // Channel code with top bit set selects the temperature sensor
  localparam int CHAN_TEMP_BIT = 3;

  // Start-of-conversion sources
  localparam logic [1:0] SRC_BUSY_WR = 2'h0;
  localparam logic [1:0] SRC_TIMER3  = 2'h1;
  localparam logic [1:0] SRC_PIN     = 2'h2;
  localparam logic [1:0] SRC_TIMER2  = 2'h3;

  // One-hot gain select bit positions
  localparam int GSEL_W    = 6;
  localparam int GSEL_HALF = 0;
  localparam int GSEL_X1   = 1;
  localparam int GSEL_X2   = 2;
  localparam int GSEL_X4   = 3;
  localparam int GSEL_X8   = 4;
  localparam int GSEL_X16  = 5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONV,
    ST_HOLD
  } sac_state_t;

endpackage

// ---- rtl/sac_sar_seq.sv ----
// Successive-approximation bit sequencer, one trial per SAR clock
`timescale 1ns/10ps
module sac_sar_seq
  import sac_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             cmp,
  output logic [RES_W-1:0]      dac_q,
  output logic [RES_W-1:0]      result_q,
  output logic                  done_q
);

  logic             busy_q;
  logic [IDX_W-1:0] idx_q;
  logic [RES_W-1:0] kept;
  logic [RES_W-1:0] cur_bit;
  logic [RES_W-1:0] nxt_bit;
  logic             last;

  function automatic logic [RES_W-1:0] bit_at(input logic [IDX_W-1:0] i);
    bit_at = RES_W'(1) << i;
  endfunction

  // Comparator high means input at or above trial level
  assign cur_bit = bit_at(idx_q);
  assign nxt_bit = last ? '0 : bit_at(idx_q - 4'h1);
  assign kept    = cmp ? dac_q : (dac_q & ~cur_bit);
  assign last    = (idx_q == '0);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busy_q   <= 1'b0;
      idx_q    <= '0;
      dac_q    <= '0;
      result_q <= '0;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
        dac_q  <= '0;
      end else if (start) begin
        busy_q <= 1'b1;
        idx_q  <= IDX_W'(RES_W - 1);
        dac_q  <= bit_at(IDX_W'(RES_W - 1));
      end else if (busy_q && tick) begin
        dac_q <= kept | nxt_bit;
        idx_q <= idx_q - 4'h1;
        if (last) begin
          busy_q   <= 1'b0;
          done_q   <= 1'b1;
          result_q <= kept;
        end
      end
    end
  end

endmodule

// ---- sim/sac_ctrl_chk.sv ----
// Port-level assertions for the converter control block
`timescale 1ns/10ps
module sac_ctrl_chk
  import sac_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic              wb_ack_o,
  input wire logic              chip_standby,
  input wire logic              converter_power,
  input wire logic              track_en,
  input wire logic [3:0]        channel_code,
  input wire logic              temp_sensor_sel,
  input wire logic [GSEL_W-1:0] gain_sel,
  input wire logic              conversion_done_flag,
  input wire logic              conversion_busy
);
  logic [15:0] blen_q;
  logic [15:0] blen_d;
  logic        bprev_q;

  // Length of the latest busy run, held once the run ends
  assign blen_d = !conversion_busy ? blen_q :
                  (bprev_q ? blen_q + 16'h0001 : 16'h0001);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      blen_q  <= 16'h0000;
      bprev_q <= 1'b0;
    end else begin
      blen_q  <= blen_d;
      bprev_q <= conversion_busy;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Two cycles of grace: power output lags the enable bit
  power_off_a: assert property (
    !converter_power && !$past(converter_power)
    |-> gain_sel == 6'h00 && !track_en && !conversion_busy)
    else $error("disabled converter still active");
  gain_onehot_a: assert property (
    converter_power && $past(converter_power) |-> $onehot(gain_sel))
    else $error("gain select not one-hot");
  temp_route_a: assert property ($stable(channel_code)
    |-> temp_sensor_sel == channel_code[CHAN_TEMP_BIT])
    else $error("temperature route mismatch");
  busy_len_a: assert property ($rose(conversion_done_flag)
    |-> blen_q >= 16'(MIN_CONV_CYC - 1)) else $error("conversion too short");
  // Abort by disable drops busy without completion
  done_set_a: assert property ($fell(conversion_busy)
    |-> ##1 (conversion_done_flag || !converter_power))
    else $error("done flag missing after busy fell");
  done_hold_a: assert property (conversion_done_flag
    && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> conversion_done_flag)
    else $error("done flag cleared by hardware");
  standby_track_a: assert property (chip_standby |=> !track_en)
    else $error("tracking during standby");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
endmodule

bind sac_ctrl sac_ctrl_chk i_sac_ctrl_chk (
  .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .chip_standby(chip_standby), .converter_power(converter_power),
  .track_en(track_en), .channel_code(channel_code),
  .temp_sensor_sel(temp_sensor_sel), .gain_sel(gain_sel),
  .conversion_done_flag(conversion_done_flag),
  .conversion_busy(conversion_busy));

// ---- sim/tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb;
  import sac_pkg::*;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [11:0]       wb_adr_i = 12'h000;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0000_0000;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              timer3_ovf = 1'b0;
  logic              timer2_ovf = 1'b0;
  logic              convert_start_pin = 1'b0;
  logic              sar_cmp_pin = 1'b0;
  logic              chip_standby = 1'b0;
  logic              converter_power;
  logic              track_en;
  logic [RES_W-1:0]  sar_dac;
  logic [RES_W-1:0]  vin = 12'hA5C;
  logic [3:0]        channel_code;
  logic [3:0]        pair_config;
  logic              temp_sensor_sel;
  logic [GSEL_W-1:0] gain_sel;
  logic              conversion_done_flag;
  logic              conversion_busy;
  logic [7:0]        rd;
  logic [1:0]        src;
  logic [1:0]        oth;
  logic [5:0]        gexp [8] = '{6'h02, 6'h04, 6'h08, 6'h10,
                                  6'h20, 6'h20, 6'h01, 6'h01};
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cyc_cnt = 0;
  int                t0;
  int                n;

  sac_ctrl i_sac_ctrl (
    .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
    .convert_start_pin(convert_start_pin), .sar_cmp_pin(sar_cmp_pin),
    .chip_standby(chip_standby), .converter_power(converter_power),
    .track_en(track_en), .sar_dac(sar_dac), .channel_code(channel_code),
    .pair_config(pair_config), .temp_sensor_sel(temp_sensor_sel),
    .gain_sel(gain_sel), .conversion_done_flag(conversion_done_flag),
    .conversion_busy(conversion_busy));

  always #2.5 core_clk = ~core_clk;

  // Ideal comparator with one flop of delay, well inside a SAR tick
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    sar_cmp_pin <= (vin >= sar_dac);
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic [9:0] idx, input logic we,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) chk("ack", 32'h0, 32'h1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e,
                       input string nm);
    xfer(idx, 1'b0, 8'h00);
    chk(nm, {24'h0, rd}, {24'h0, e});
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    do begin
      xfer(IDX_CONV_CTRL, 1'b0, 8'h00);
      k++;
    end while (rd[CTL_DONE] !== 1'b1 && k < 1500);
    chk("done bit", {31'h0, rd[CTL_DONE]}, 32'h1);
  endtask

  task automatic fire(input logic [1:0] s);
    @(posedge core_clk);
    case (s)
      SRC_TIMER3: timer3_ovf <= 1'b1;
      SRC_TIMER2: timer2_ovf <= 1'b1;
      default:    convert_start_pin <= 1'b1;
    endcase
    @(posedge core_clk);
    timer3_ovf <= 1'b0;
    timer2_ovf <= 1'b0;
    repeat (20) @(posedge core_clk);
    convert_start_pin <= 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rdchk(IDX_PAIR_CFG, 8'h00, "pair cfg reset");
    rdchk(IDX_CONV_CFG, 8'hF8, "conv cfg reset");
    rdchk(IDX_CONV_CTRL, 8'h00, "ctrl reset");
    chk("gain off", gain_sel, 6'h00);
    wr(10'h0B0, 8'h55);
    rdchk(10'h0B0, 8'h00, "unmapped");
    wr(IDX_PAIR_CFG, 8'hF5);
    rdchk(IDX_PAIR_CFG, 8'h05, "pair cfg");
    chk("pair port", pair_config, 4'h5);
    wr(IDX_CHAN_SEL, 8'h08);
    rdchk(IDX_CHAN_SEL, 8'h08, "chan sel");
    chk("temp sel", temp_sensor_sel, 1'b1);
    wr(IDX_CHAN_SEL, 8'h07);
    repeat (2) @(posedge core_clk);
    chk("ext sel", {temp_sensor_sel, channel_code}, 5'h07);
    $display("test registers done");
    wr(IDX_CONV_CTRL, 8'h80);
    for (int g = 0; g < 8; g++) begin
      wr(IDX_CONV_CFG, 8'h38 | 8'(g));
      repeat (2) @(posedge core_clk);
      chk("gain decode", gain_sel, gexp[g]);
    end
    wr(IDX_CONV_CFG, 8'h38);
    chk("track idle", track_en, 1'b1);
    chip_standby <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("track standby", track_en, 1'b0);
    chip_standby <= 1'b0;
    repeat (3) @(posedge core_clk);
    $display("test gain and tracking done");
    wr(IDX_CONV_CTRL, 8'h90);
    t0 = cyc_cnt;
    repeat (1000) @(posedge core_clk);
    wr(IDX_CONV_CTRL, 8'h90);
    wait_done();
    chk("no restart", cyc_cnt - t0 < 2100, 1);
    rdchk(IDX_RES_LOW, vin[7:0], "right low");
    rdchk(IDX_RES_HIGH, {4'h0, vin[11:8]}, "right high");
    rdchk(IDX_CONV_CTRL, 8'hA0, "ctrl after");
    wr(IDX_CONV_CTRL, 8'h80);
    rdchk(IDX_CONV_CTRL, 8'h80, "done cleared");
    vin <= 12'h3C7;
    wr(IDX_CONV_CTRL, 8'h91);
    repeat (3) @(posedge core_clk);
    chk("busy", conversion_busy, 1'b1);
    wait_done();
    rdchk(IDX_RES_HIGH, vin[11:4], "left high");
    rdchk(IDX_RES_LOW, {vin[3:0], 4'h0}, "left low");
    $display("test software start done");
    for (int s = 1; s < 4; s++) begin
      src = 2'(s);
      oth = (src == SRC_TIMER3) ? SRC_TIMER2 : src - 2'h1;
      wr(IDX_CONV_CTRL, {4'h8, src, 2'h0});
      fire(oth);
      repeat (10) @(posedge core_clk);
      chk("wrong source", conversion_busy, 1'b0);
      fire(src);
      repeat (10) @(posedge core_clk);
      chk("source start", conversion_busy, 1'b1);
      wait_done();
      wr(IDX_CONV_CTRL, {4'h8, src, 2'h0});
    end
    $display("test start sources done");
    wr(IDX_CONV_CTRL, 8'hC0);
    repeat (3) @(posedge core_clk);
    chk("lp idle track", track_en, 1'b0);
    wr(IDX_CONV_CTRL, 8'hD0);
    n = 0;
    repeat (300) begin
      @(posedge core_clk);
      if (track_en === 1'b1) n++;
    end
    chk("lp track len", n, 3 * 8);
    wait_done();
    // Pin source in low-power mode: track while low, convert on rise
    wr(IDX_CONV_CTRL, 8'hC8);
    repeat (4) @(posedge core_clk);
    chk("lp pin low track", track_en, 1'b1);
    convert_start_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("lp pin convert", {conversion_busy, track_en}, 2'h2);
    wait_done();
    convert_start_pin <= 1'b0;
    rdchk(IDX_RES_LOW, vin[7:0], "pin result");
    $display("test low power done");
    wr(IDX_CONV_CTRL, 8'h90);
    repeat (100) @(posedge core_clk);
    wr(IDX_CONV_CTRL, 8'h00);
    repeat (2300) @(posedge core_clk);
    chk("abort", {conversion_done_flag, conversion_busy, converter_power,
        sar_dac}, 15'h0000);
    $display("test disable done");
    conclude();
  end
endmodule
